// File: design/shadow_push_defs.svh
`ifndef SHADOW_PUSH_DEFS_SVH
`define SHADOW_PUSH_DEFS_SVH

// ----------------------------------------
// opcode patterns
// ----------------------------------------
`define OPC_RESTORE    24'hfe8000
`define OPC_SAVE       24'hfea000
`define OPC_PUSHF_HI   8'hf8
`define OPC_PUSHW_MASK 24'hf87f80
`define OPC_PUSHW_VAL  24'h781f80

// ----------------------------------------
// stack and status word layout
// ----------------------------------------
`define SP_IDX    4'hf
`define SP_STEP   16'h0002
`define FLD_C     0
`define FLD_Z     1
`define FLD_OVF   2
`define FLD_N     3
`define FLD_DIGC  8
`define FLAG_MASK 16'h010f

// ----------------------------------------
// register map and reset values
// ----------------------------------------
`define REG_STATUS  8'h00
`define REG_CTRL    8'h04
`define REG_RETIRED 8'h08
`define REG_WBASE   2'b01
`define CTRL_RST    1'b1
`define STATUS_RST  16'h0000
`define RESP_OKAY   2'b00
`define RESP_SLVERR 2'b10

`endif

// File: design/shadow_push_pkg.sv
package shadow_push_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RD   = 2'b01,
    ST_CAP  = 2'b10,
    ST_WR   = 2'b11
  } exec_state_t;

  typedef enum logic [2:0] {
    AM_DIRECT  = 3'b000,
    AM_IND     = 3'b001,
    AM_POSTDEC = 3'b010,
    AM_POSTINC = 3'b011,
    AM_PREDEC  = 3'b100,
    AM_PREINC  = 3'b101,
    AM_OFFS    = 3'b110,
    AM_OFFS_B  = 3'b111
  } amode_t;

  typedef struct packed {
    logic        en;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dmem_req_t;

  typedef struct packed {
    logic digc;
    logic n;
    logic ovf;
    logic z;
    logic c;
  } flags_t;

endpackage

// File: design/stack_push_shadow_restore.sv
`timescale 1ns/1ps
`include "shadow_push_defs.svh"
// Functional notes
// - opcode fe8000 is shadow restore, one word, no operands
// - restore copies shadows back to low_working_regs and five arithmetic flags
// - restore touches only the five arithmetic flags; other status fields kept
// - shadow storage has no address path; only save and restore reach it
// - shadow storage is one level; a second save overwrites
// - restore leaves shadow storage unchanged
// - upper byte f8 is push file register; bits 15:1 address, bit 0 zero
// - push file register writes word at stack pointer, then adds 2; no flags
// - file address reaches lower 32K words, values 0 to 65534
// - both pushes move a full 16-bit word; no byte variant
// - pattern 0111 1www w001 1111 1ggg ssss is push working register operand
// - push operand is word move to stack top, then stack pointer plus 2
// - source supports direct, indirect, post/pre inc/dec and register plus offset
// - restore and save take one cycle; file and indirect pushes take four, direct register push two
// - opcode fea000 saves low_working_regs and five flags into shadows
module stack_push_shadow_restore (
  input  wire logic                      CORE_CLK,
  input  wire logic                      NRST,
  input  wire logic                      INSTR_VALID,
  input  wire logic [23:0]               INSTR_WORD,
  output      logic                      INSTR_READY,
  output      shadow_push_pkg::dmem_req_t DMEM_REQ,
  input  wire logic [15:0]               DMEM_RDATA,
  input  wire logic [7:0]                S_AXI_AWADDR,
  input  wire logic                      S_AXI_AWVALID,
  output      logic                      S_AXI_AWREADY,
  input  wire logic [31:0]               S_AXI_WDATA,
  input  wire logic [3:0]                S_AXI_WSTRB,
  input  wire logic                      S_AXI_WVALID,
  output      logic                      S_AXI_WREADY,
  output      logic [1:0]                S_AXI_BRESP,
  output      logic                      S_AXI_BVALID,
  input  wire logic                      S_AXI_BREADY,
  input  wire logic [7:0]                S_AXI_ARADDR,
  input  wire logic                      S_AXI_ARVALID,
  output      logic                      S_AXI_ARREADY,
  output      logic [31:0]               S_AXI_RDATA,
  output      logic [1:0]                S_AXI_RRESP,
  output      logic                      S_AXI_RVALID,
  input  wire logic                      S_AXI_RREADY
);
  import shadow_push_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0]        rsync;
  logic              rst_n;
  exec_state_t       state, next_state;
  logic [15:0][15:0] wreg, next_wreg;
  logic [3:0][15:0]  sh_w, next_sh_w;
  flags_t            sh_f, next_sh_f;
  logic [15:0]       status_word, next_status_word, retired, next_retired;
  logic              ctrl_en, next_ctrl_en, next_ready;
  dmem_req_t         next_req;
  logic              fire, is_rst, is_sav, is_pf, is_pw;
  amode_t            gmode;
  logic [3:0]        src_idx, off_idx;
  logic [15:0]       src_val, ea;
  logic              aw_got, next_aw_got, w_got, next_w_got, wr_go;
  logic [7:0]        awaddr_q, next_awaddr_q;
  logic [15:0]       wdata_q, next_wdata_q;
  logic [1:0]        wstrb_q, next_wstrb_q, next_bresp, next_rresp;
  logic              next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [31:0]       next_rdata;
  logic [15:0]       wr_hit;

  // two flops so release never lands mid-cycle for the core
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      rsync <= 2'b00;
    end else begin
      rsync <= {rsync[0], 1'b1};
    end
  end
  assign rst_n = rsync[1];

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a == `REG_STATUS || a == `REG_CTRL ||
             a == `REG_RETIRED || a[7:6] == `REG_WBASE);
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
                                        input logic [1:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic flags_t pick_flags(input logic [15:0] w);
    pick_flags = '{digc: w[`FLD_DIGC], n: w[`FLD_N], ovf: w[`FLD_OVF],
                   z: w[`FLD_Z], c: w[`FLD_C]};
  endfunction

  function automatic logic [15:0] place_flags(input flags_t f);
    place_flags = '0;
    place_flags[`FLD_DIGC] = f.digc;
    place_flags[`FLD_N]    = f.n;
    place_flags[`FLD_OVF]  = f.ovf;
    place_flags[`FLD_Z]  = f.z;
    place_flags[`FLD_C]  = f.c;
  endfunction

  // ----------------------------------------
  // instruction decode
  // ----------------------------------------
  assign fire    = (state == ST_IDLE) && INSTR_VALID && INSTR_READY;
  assign is_rst  = (INSTR_WORD == `OPC_RESTORE);
  assign is_sav  = (INSTR_WORD == `OPC_SAVE);
  assign is_pf   = (INSTR_WORD[23:16] == `OPC_PUSHF_HI);
  assign is_pw   = ((INSTR_WORD & `OPC_PUSHW_MASK) == `OPC_PUSHW_VAL);
  assign gmode   = amode_t'(INSTR_WORD[6:4]);
  assign src_idx = INSTR_WORD[3:0];
  assign off_idx = INSTR_WORD[18:15];
  assign src_val = wreg[src_idx];

  // effective source address per mode
  always_comb begin
    case (gmode)
      AM_PREDEC:          ea = src_val - `SP_STEP;
      AM_PREINC:          ea = src_val + `SP_STEP;
      AM_OFFS, AM_OFFS_B: ea = src_val + wreg[off_idx];
      default:            ea = src_val;
    endcase
  end

  // per-register software write selects
  for (genvar i = 0; i < 16; i++) begin : g_hit
    assign wr_hit[i] = wr_go && (awaddr_q == {`REG_WBASE, 4'(i), 2'b00});
  end

  // ----------------------------------------
  // register bus slave
  // ----------------------------------------
  // address and data may arrive in either order; one response at a time
  always_comb begin
    next_aw_got   = aw_got;
    next_w_got    = w_got;
    next_awaddr_q = awaddr_q;
    next_wdata_q  = wdata_q;
    next_wstrb_q  = wstrb_q;
    next_bvalid   = S_AXI_BVALID;
    next_bresp    = S_AXI_BRESP;
    next_rvalid   = S_AXI_RVALID;
    next_rresp    = S_AXI_RRESP;
    next_rdata    = S_AXI_RDATA;
    wr_go         = aw_got && w_got && !S_AXI_BVALID;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      next_aw_got   = 1'b1;
      next_awaddr_q = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      next_w_got   = 1'b1;
      next_wdata_q = S_AXI_WDATA[15:0];
      next_wstrb_q = S_AXI_WSTRB[1:0];
    end
    if (S_AXI_BVALID && S_AXI_BREADY) begin
      next_bvalid = 1'b0;
    end
    if (wr_go) begin
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
    end
    next_awready = !next_aw_got && !next_bvalid;
    next_wready  = !next_w_got && !next_bvalid;
    if (S_AXI_RVALID && S_AXI_RREADY) begin
      next_rvalid = 1'b0;
    end
    // shadow storage is deliberately absent from this map
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      next_rvalid = 1'b1;
      next_rresp  = mapped(S_AXI_ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
      next_rdata  = '0;
      if (S_AXI_ARADDR == `REG_STATUS) begin
        next_rdata = {16'h0000, status_word};
      end else if (S_AXI_ARADDR == `REG_CTRL) begin
        next_rdata = {31'h0, ctrl_en};
      end else if (S_AXI_ARADDR == `REG_RETIRED) begin
        next_rdata = {16'h0000, retired};
      end else if (mapped(S_AXI_ARADDR)) begin
        next_rdata = {16'h0000, wreg[S_AXI_ARADDR[5:2]]};
      end
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `RESP_OKAY;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RRESP   <= `RESP_OKAY;
      S_AXI_RDATA   <= '0;
    end else begin
      aw_got        <= next_aw_got;
      w_got         <= next_w_got;
      awaddr_q      <= next_awaddr_q;
      wdata_q       <= next_wdata_q;
      wstrb_q       <= next_wstrb_q;
      S_AXI_AWREADY <= next_awready;
      S_AXI_WREADY  <= next_wready;
      S_AXI_BVALID  <= next_bvalid;
      S_AXI_BRESP   <= next_bresp;
      S_AXI_ARREADY <= next_arready;
      S_AXI_RVALID  <= next_rvalid;
      S_AXI_RRESP   <= next_rresp;
      S_AXI_RDATA   <= next_rdata;
    end
  end

  // ----------------------------------------
  // execute
  // ----------------------------------------
  // software writes go first; a colliding instruction effect wins
  always_comb begin
    next_state   = state;
    next_wreg    = wreg;
    next_sh_w    = sh_w;
    next_sh_f    = sh_f;
    next_status_word = status_word;
    next_retired = retired;
    next_ctrl_en = ctrl_en;
    next_req     = DMEM_REQ;
    next_req.en  = 1'b0;
    next_req.we  = 1'b0;
    if (wr_go && awaddr_q == `REG_STATUS) begin
      next_status_word = merge(status_word, wdata_q, wstrb_q);
    end
    if (wr_go && awaddr_q == `REG_CTRL && wstrb_q[0]) begin
      next_ctrl_en = wdata_q[0];
    end
    for (int i = 0; i < 16; i++) begin
      if (wr_hit[i]) begin
        next_wreg[i] = merge(wreg[i], wdata_q, wstrb_q);
      end
    end
    case (state)
      ST_IDLE: begin
        if (fire && is_rst) begin
          next_wreg[3:0] = sh_w;
          next_status_word = (status_word & ~`FLAG_MASK) | place_flags(sh_f);
          next_retired   = retired + 16'h0001;
        end else if (fire && is_sav) begin
          next_sh_w    = wreg[3:0];
          next_sh_f    = pick_flags(status_word);
          next_retired = retired + 16'h0001;
        end else if (fire && is_pf) begin
          next_req.en   = 1'b1;
          next_req.addr = {INSTR_WORD[15:1], 1'b0};
          next_state    = ST_RD;
        end else if (fire && is_pw && gmode == AM_DIRECT) begin
          next_req.en         = 1'b1;
          next_req.we         = 1'b1;
          next_req.addr       = wreg[`SP_IDX];
          next_req.wdata      = src_val;
          next_wreg[`SP_IDX]  = wreg[`SP_IDX] + `SP_STEP;
          next_state          = ST_WR;
        end else if (fire && is_pw) begin
          next_req.en   = 1'b1;
          next_req.addr = ea;
          next_state    = ST_RD;
          case (gmode)
            AM_POSTDEC:         next_wreg[src_idx] = src_val - `SP_STEP;
            AM_POSTINC:         next_wreg[src_idx] = src_val + `SP_STEP;
            AM_PREDEC, AM_PREINC: next_wreg[src_idx] = ea;
            default:            next_wreg[src_idx] = src_val;
          endcase
        end
      end
      ST_RD: begin
        next_state = ST_CAP;
      end
      // memory answers one cycle after the read strobe
      ST_CAP: begin
        next_req.en        = 1'b1;
        next_req.we        = 1'b1;
        next_req.addr      = wreg[`SP_IDX];
        next_req.wdata     = DMEM_RDATA;
        next_wreg[`SP_IDX] = wreg[`SP_IDX] + `SP_STEP;
        next_state         = ST_WR;
      end
      ST_WR: begin
        next_retired = retired + 16'h0001;
        next_state   = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    next_ready = next_ctrl_en && (next_state == ST_IDLE);
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state       <= ST_IDLE;
      wreg        <= '0;
      sh_w        <= '0;
      sh_f        <= '0;
      status_word <= `STATUS_RST;
      retired     <= '0;
      ctrl_en     <= `CTRL_RST;
      DMEM_REQ    <= '0;
      INSTR_READY <= 1'b0;
    end else begin
      state       <= next_state;
      wreg        <= next_wreg;
      sh_w        <= next_sh_w;
      sh_f        <= next_sh_f;
      status_word <= next_status_word;
      retired     <= next_retired;
      ctrl_en     <= next_ctrl_en;
      DMEM_REQ    <= next_req;
      INSTR_READY <= next_ready;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!rst_n);

  AST_RESTORE_REGS: assert property (fire && is_rst |=> wreg[3:0] == $past(sh_w))
    else $error("restore did not reload low working regs");
  AST_RESTORE_STATUS: assert property (fire && is_rst |=>
    (status_word & ~`FLAG_MASK) == ($past(status_word) & ~`FLAG_MASK) &&
    pick_flags(status_word) == $past(sh_f))
    else $error("restore disturbed status fields");
  AST_RESTORE_KEEP: assert property (fire && is_rst |=> $stable(sh_w) && $stable(sh_f))
    else $error("restore changed shadow storage");
  AST_SAVE: assert property (fire && is_sav |=> sh_w == $past(wreg[3:0]) &&
    sh_f == pick_flags($past(status_word)))
    else $error("save did not capture primaries");
  AST_SHADOW_GUARD: assert property (!(fire && is_sav) |=> $stable(sh_w) && $stable(sh_f))
    else $error("shadow storage written without save");
  AST_PUSHF_READ: assert property (fire && is_pf |=> DMEM_REQ.en && !DMEM_REQ.we &&
    DMEM_REQ.addr == {$past(INSTR_WORD[15:1]), 1'b0})
    else $error("file push read address wrong");
  AST_PUSHF_WRITE: assert property (fire && is_pf |=> ##2 DMEM_REQ.en && DMEM_REQ.we &&
    DMEM_REQ.wdata == $past(DMEM_RDATA) && wreg[`SP_IDX] == $past(wreg[`SP_IDX], 3) + `SP_STEP)
    else $error("file push write or stack step wrong");
  AST_PUSHW_DIRECT: assert property (fire && is_pw && gmode == AM_DIRECT |=>
    DMEM_REQ.we && DMEM_REQ.wdata == $past(src_val) && DMEM_REQ.addr == $past(wreg[`SP_IDX]))
    else $error("register push wrote wrong word");
  AST_POSTINC: assert property (fire && is_pw && gmode == AM_POSTINC &&
    src_idx != `SP_IDX |=> wreg[$past(src_idx)] == $past(src_val) + `SP_STEP)
    else $error("post-increment source not stepped");
  AST_PUSH_DONE: assert property (fire && is_pf |=> ##3 state == ST_IDLE)
    else $error("file push did not finish in time");

  COV_RESTORE: cover property (fire && is_rst);
  COV_SAVE_RESTORE: cover property (fire && is_sav ##1 fire && is_rst);
  COV_PUSHF: cover property (fire && is_pf ##3 DMEM_REQ.we);
  COV_PUSHW_OFFS: cover property (fire && is_pw && gmode == AM_OFFS);

endmodule

// File: dv/stack_push_shadow_restore_test.sv
`timescale 1ns/1ps
`include "shadow_push_defs.svh"
module stack_push_shadow_restore_test;
  import shadow_push_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        clk;
  logic        nrst;
  logic        instr_valid;
  logic [23:0] instr_word;
  logic        instr_ready;
  dmem_req_t   dmem_req;
  logic [15:0] dmem_rdata;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [15:0] mem [0:32767];
  int          n_errors;
  int          n_compared;
  int          n_ret;
  // indirect modes 1..7 on w4 = 0100 with w6 = 0004 as offset
  localparam logic [15:0] A_EXP [1:7] = '{16'h0100, 16'h0100, 16'h0100, 16'h00fe,
                                          16'h0102, 16'h0104, 16'h0104};
  localparam logic [15:0] W_EXP [1:7] = '{16'h0100, 16'h00fe, 16'h0102, 16'h00fe,
                                          16'h0102, 16'h0100, 16'h0100};

  stack_push_shadow_restore dut (
    .CORE_CLK(clk), .NRST(nrst), .INSTR_VALID(instr_valid), .INSTR_WORD(instr_word),
    .INSTR_READY(instr_ready), .DMEM_REQ(dmem_req), .DMEM_RDATA(dmem_rdata),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
  );

  // 8 ns core clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // data memory: one-cycle read, data line not held past its cycle
  always @(posedge clk) begin
    if (dmem_req.en && dmem_req.we) begin
      mem[dmem_req.addr[15:1]] <= dmem_req.wdata;
    end
    if (dmem_req.en && !dmem_req.we) begin
      dmem_rdata <= mem[dmem_req.addr[15:1]];
    end else begin
      dmem_rdata <= ~dmem_rdata;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] pat(input logic [15:0] a);
    return {a[15:1], 1'b0} ^ 16'h5a5a;
  endfunction

  function automatic logic [7:0] wa(input int n);
    return 8'h40 + 8'(4 * n);
  endfunction

  task automatic give_verdict();
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic timed_out(input string what);
    n_errors++;
    $display("BAD %s expected handshake seen timeout", what);
    give_verdict();
  endtask

  // ----------------------------------------
  // bus and instruction tasks
  // ----------------------------------------
  // each channel released only at the edge that takes it
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int k;
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (k == 100) timed_out("axi write");
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int k;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (k == 100) timed_out("axi read");
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [1:0] r;
    axi_wr(a, {16'h0000, d}, r);
    chk("write response", 32'(`RESP_OKAY), 32'(r));
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [1:0]  r;
    logic [31:0] d;
    axi_rd(a, d, r);
    chk(what, exp, d);
  endtask

  // offer one opcode, then count edges until ready comes back
  task automatic issue(input logic [23:0] op, input int exp_cyc);
    int k;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word  <= op;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (instr_ready) break;
    end
    if (k == 100) timed_out("instruction take");
    instr_valid <= 1'b0;
    for (k = 1; k <= 100; k++) begin
      @(posedge clk);
      if (instr_ready) break;
    end
    if (k > 100) timed_out("instruction done");
    // every timed opcode retires, so the expected count follows it here
    if (exp_cyc > 0) begin
      n_ret++;
      chk("ready return cycles", 32'(exp_cyc), 32'(k));
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    nrst = 1'b0;
    instr_valid = 1'b0;
    instr_word = 24'h000000;
    dmem_rdata = 16'h0000;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hf;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    n_errors = 0;
    n_compared = 0;
    n_ret = 0;
    for (int i = 0; i < 32768; i++) mem[i] = pat(16'(2 * i));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd("status reset", `REG_STATUS, 32'h0);
    rd("ctrl reset", `REG_CTRL, 32'h1);
    axi_rd(8'hc0, d, r);
    chk("unmapped read resp", 32'(`RESP_SLVERR), 32'(r));
    chk("unmapped read data", 32'h0, d);
    axi_wr(8'hc4, 32'h1234, r);
    chk("unmapped write resp", 32'(`RESP_SLVERR), 32'(r));
    // shadow restore of reset-cleared shadows gives zeros
    wr(wa(1), 16'hbeef);
    issue(`OPC_RESTORE, 1);
    rd("low reg from cleared shadow", wa(1), 32'h0);
    // save all flags, then restore over foreign status bits
    for (int i = 0; i < 4; i++) wr(wa(i), {i[3:0], 12'h000});
    wr(`REG_STATUS, 16'h010f);
    issue(`OPC_SAVE, 1);
    for (int i = 0; i < 4; i++) wr(wa(i), 16'h07bb ^ 16'(i));
    wr(`REG_STATUS, 16'hfef0);
    issue(`OPC_RESTORE, 1);
    for (int i = 0; i < 4; i++) rd("low reg restored", wa(i), {i[3:0], 12'h000});
    rd("status restored", `REG_STATUS, 32'hffff);
    // second restore reloads the same values
    wr(wa(0), 16'h4321);
    issue(`OPC_RESTORE, 1);
    rd("low reg restored twice", wa(0), 32'h0);
    // second save overwrites the single level
    for (int i = 0; i < 4; i++) wr(wa(i), 16'ha000 | 16'(i));
    wr(`REG_STATUS, 16'hfef0);
    issue(`OPC_SAVE, 1);
    for (int i = 0; i < 4; i++) wr(wa(i), 16'h0000);
    wr(`REG_STATUS, 16'hffff);
    issue(`OPC_RESTORE, 1);
    for (int i = 0; i < 4; i++) rd("low reg after resave", wa(i), 32'ha000 | i);
    rd("status flags cleared", `REG_STATUS, 32'hfef0);
    // push file register, including the top of the address range
    wr(`REG_STATUS, 16'h0005);
    wr(wa(15), 16'h0b00);
    issue(24'hf82004, 4);
    issue(24'hf8fffe, 4);
    chk("pushed file word", pat(16'h2004), mem[15'h0580]);
    chk("pushed top file word", pat(16'hfffe), mem[15'h0581]);
    rd("sp after file pushes", wa(15), 32'h0b04);
    rd("status after file pushes", `REG_STATUS, 32'h0005);
    // push working register direct
    wr(wa(2), 16'h6889);
    wr(wa(15), 16'h1566);
    issue(24'h781f82, 2);
    chk("pushed register word", 32'h6889, mem[15'h0ab3]);
    rd("sp after register push", wa(15), 32'h1568);
    rd("source register kept", wa(2), 32'h6889);
    // every indirect mode on w4, offset register w6
    for (int g = 1; g < 8; g++) begin
      wr(wa(4), 16'h0100);
      wr(wa(6), 16'h0004);
      wr(wa(15), 16'h0a00);
      issue({5'b01111, 4'h6, 3'b001, 4'hf, 1'b1, 3'(g), 4'h4}, 4);
      chk("pushed indirect word", pat(A_EXP[g]), mem[15'h0500]);
      rd("source after mode", wa(4), W_EXP[g]);
      rd("sp after mode", wa(15), 32'h0a02);
    end
    rd("status after pushes", `REG_STATUS, 32'h0005);
    // unknown opcode is consumed without retiring
    issue(24'hfe4000, 0);
    rd("retired count", `REG_RETIRED, 32'(n_ret));
    // execution disabled holds ready low
    wr(`REG_CTRL, 16'h0000);
    repeat (2) @(posedge clk);
    chk("ready when disabled", 32'h0, 32'(instr_ready));
    wr(`REG_CTRL, 16'h0001);
    give_verdict();
  end
endmodule
